/* File: logic/twm_pkg.sv */
// constants and types shared by the two-wire master files
// assumes a 32-bit register bus with byte offsets below 0x100
package twm_pkg;
  localparam int          ADDR_W     = 8;
  // ****************
  // register offsets
  // ****************
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_MODE   = 8'h04;
  localparam logic [7:0]  OFF_SUBA   = 8'h0c;
  localparam logic [7:0]  OFF_WAVE   = 8'h10;
  localparam logic [7:0]  OFF_STAT   = 8'h20;
  localparam logic [7:0]  OFF_IEN    = 8'h24;
  localparam logic [7:0]  OFF_IDIS   = 8'h28;
  localparam logic [7:0]  OFF_IMSK   = 8'h2c;
  localparam logic [7:0]  OFF_RXH    = 8'h30;
  localparam logic [7:0]  OFF_TXH    = 8'h34;
  // ****************
  // field positions
  // ****************
  localparam int          CR_START   = 0;
  localparam int          CR_STOP    = 1;
  localparam int          CR_MON     = 2;
  localparam int          CR_MOFF    = 3;
  localparam int          CR_SRST    = 7;
  localparam int          MM_SZ_LO   = 8;
  localparam int          MM_RD      = 12;
  localparam int          MM_DA_LO   = 16;
  localparam int          WV_CL_LO   = 0;
  localparam int          WV_CH_LO   = 8;
  localparam int          WV_CK_LO   = 16;
  localparam int          ST_DONE    = 0;
  localparam int          ST_RXR     = 1;
  localparam int          ST_TXF     = 2;
  localparam int          ST_NAK     = 8;
  // internal flag vector order
  localparam int          F_DONE     = 0;
  localparam int          F_RXR      = 1;
  localparam int          F_TXF      = 2;
  localparam int          F_NAK      = 3;
  // ****************
  // reset values and timing
  // ****************
  localparam logic [31:0] MODE_RST   = 32'h0000_0000;
  localparam logic [31:0] SUBA_RST   = 32'h0000_0000;
  localparam logic [31:0] WAVE_RST   = 32'h0000_0000;
  localparam logic [31:0] STAT_RST   = 32'h0000_0008;
  localparam logic [15:0] PH_FIX     = 16'h0003;
  localparam logic [15:0] PH_LAT     = 16'h0002;
  typedef enum logic [3:0] {
    S_IDLE, S_SRISE, S_SFALL, S_BLOW, S_BHIGH, S_PLOW, S_PHIGH, S_PEND, S_RSLOW
  } twm_st_t;
  typedef enum logic [1:0] {PH_ADDR, PH_SUB, PH_DATA} twm_ph_t;
endpackage

/* File: logic/twm_tmr_if.sv */
// phase timer hookup between the core and its timer
// assumes both ends on sys_clk_i
`timescale 1ns/10ps
interface twm_tmr_if;
  logic        load;
  logic [15:0] cnt;
  logic        done;
  modport ctl (output load, output cnt, input done);
  modport tmr (input load, input cnt, output done);
endinterface

/* File: logic/twm_phase_timer.sv */
// down counter timing one serial clock phase
// assumes load pulses only while idle or after done
`timescale 1ns/10ps
module twm_phase_timer (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  twm_tmr_if.tmr    tmr_io
);
  typedef struct packed {
    logic        run;
    logic [15:0] cnt;
  } twm_tmr_t;
  twm_tmr_t r_q, r_d;

  always_comb begin
    r_d = r_q;
    if (tmr_io.load) begin
      r_d.run = 1'b1;
      r_d.cnt = tmr_io.cnt;
    end else if (r_q.run) begin
      if (r_q.cnt == 16'h0000) r_d.run = 1'b0;
      else r_d.cnt = r_q.cnt - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) r_q <= '0;
    else r_q <= r_d;
  end

  assign tmr_io.done = r_q.run && (r_q.cnt == 16'h0000);
endmodule

/* File: logic/twm_pin_sync.sv */
// three-stage input synchroniser with agreement filter
// assumes the line idles high
`timescale 1ns/10ps
module twm_pin_sync (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      lvl_o
);
  typedef struct packed {
    logic f1, f2, f3, lvl;
  } twm_sync_t;
  twm_sync_t r_q, r_d;

  // f1 feeds only f2: metastability stays in the first stage
  always_comb begin
    r_d     = r_q;
    r_d.f1  = pin_i;
    r_d.f2  = r_q.f1;
    r_d.f3  = r_q.f2;
    if (r_q.f2 == r_q.f3) r_d.lvl = r_q.f3;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) r_q <= '1;
    else r_q <= r_d;
  end

  assign lvl_o = r_q.lvl;
endmodule

/* File: logic/twm_core.sv */
// register-programmed two-wire serial master with AXI4-Lite slave
// assumes open-drain pads outside and pull-ups on both lines
//
// Summary of operation
// - start bit launches a frame
// - write direction: holding write launches frame
// - stop bit ends read after byte
// - missing acknowledge forces a stop
// - write frame stops when bytes run out
// - enable bit works unless disable set
// - disable waits for pending bytes
// - soft reset clears core registers, keeping the write response and pending read answer
// - size field picks sub-address byte count
// - direction bit picks read or write
// - sub-address register feeds sub-address bytes
// - low phase length from low divider
// - high phase length from high divider
// - exponent scales both phases
// - done flag low from start until stop or missing acknowledge
// - receive flag set on byte, read clears
// - transmit-free flag rules
// - not_acked_flag flag with done, read clears
// - enable and disable registers set mask
// - address byte is device address plus direction
// - ninth pulse is acknowledge slot
// - master acknowledges all but last byte
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module twm_core (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_i,
  input  wire logic [twm_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                      s_axi_awvalid_i,
  output logic                           s_axi_awready_o,
  input  wire logic [31:0]               s_axi_wdata_i,
  input  wire logic [3:0]                s_axi_wstrb_i,
  input  wire logic                      s_axi_wvalid_i,
  output logic                           s_axi_wready_o,
  output logic [1:0]                     s_axi_bresp_o,
  output logic                           s_axi_bvalid_o,
  input  wire logic                      s_axi_bready_i,
  input  wire logic [twm_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                      s_axi_arvalid_i,
  output logic                           s_axi_arready_o,
  output logic [31:0]                    s_axi_rdata_o,
  output logic [1:0]                     s_axi_rresp_o,
  output logic                           s_axi_rvalid_o,
  input  wire logic                      s_axi_rready_i,
  output logic                           serial_clock_pin_o,
  output logic                           serial_clock_pin_oe_o,
  input  wire logic                      serial_data_pin_i,
  output logic                           serial_data_pin_o,
  output logic                           serial_data_pin_oe_o,
  output logic                           irq_o
);
  import twm_pkg::*;

  typedef struct packed {
    twm_st_t     st;
    twm_ph_t     ph;
    logic        go, dbit, scl_oe, sda_oe;
    logic        en, off_pend, start_pend, stop_req, thr_full;
    logic        rd_frame, addr_rd, last;
    logic [1:0]  subn, sz;
    logic [3:0]  bitn, flg, msk;
    logic [7:0]  sh, thr, rhr, cl, ch;
    logic        mrd;
    logic [6:0]  slave_device_addr;
    logic [23:0] suba;
    logic [2:0]  ck;
    logic        aw, w, bv, rv, awr, wrdy, arr, irq;
    logic [7:0]  wa;
    logic [31:0] wd, rd;
    logic [3:0]  ws;
  } twm_core_t;

  twm_core_t r, n;
  logic      sda_s, tdone, wr_go, rd_go, rd_hit, srst, rx, b;
  logic      ld_sub, ld_dat, ld_tx, go_stop;
  logic [1:0]  six;
  logic [7:0]  wa_w, ra_w;
  logic [15:0] nlo, nhi;
  logic [31:0] wv;

  twm_tmr_if tif ();
  twm_phase_timer u_tmr (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .tmr_io(tif.tmr));
  twm_pin_sync u_sda (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     (serial_data_pin_i),
    .lvl_o     (sda_s)
  );

  // ****************
  // helpers
  // ****************
  function automatic twm_core_t mv(twm_core_t s, twm_st_t t, logic c, logic d);
    s.st = t;
    s.go = 1'b1;
    s.scl_oe = c;
    // sda moves a cycle after scl falls, never with it
    if (c) s.dbit = d;
    else s.sda_oe = d;
    return s;
  endfunction

  function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] v, logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (o & ~m) | (v & m);
  endfunction

  function automatic logic [31:0] f2w(logic [3:0] f);
    return (32'(f[F_NAK]) << ST_NAK) | (32'(f[F_TXF]) << ST_TXF) |
           (32'(f[F_RXR]) << ST_RXR) | (32'(f[F_DONE]) << ST_DONE);
  endfunction

  function automatic logic [3:0] w2f(logic [31:0] v);
    return {v[ST_NAK], v[ST_TXF], v[ST_RXR], v[ST_DONE]};
  endfunction

  logic [31:0] mode_v, wave_v;
  assign mode_v = (32'(r.slave_device_addr) << MM_DA_LO) | (32'(r.mrd) << MM_RD) | (32'(r.sz) << MM_SZ_LO);
  assign wave_v = (32'(r.ck) << WV_CK_LO) | (32'(r.ch) << WV_CH_LO) | (32'(r.cl) << WV_CL_LO);
  assign wa_w = {r.wa[7:2], 2'b00};
  assign ra_w = {s_axi_araddr_i[7:2], 2'b00};
  assign nlo = (16'({8'h00, r.cl}) << r.ck) + PH_FIX;
  assign nhi = (16'({8'h00, r.ch}) << r.ck) + PH_FIX;
  assign tif.load = r.go && (r.st != S_IDLE);
  assign tif.cnt  = (r.scl_oe ? nlo : nhi) - PH_LAT;
  assign tdone    = tif.done;

  // ****************
  // next state
  // ****************
  always_comb begin
    n = r;
    wr_go = 1'b0; rd_go = 1'b0; rd_hit = 1'b0; srst = 1'b0;
    ld_sub = 1'b0; ld_dat = 1'b0; ld_tx = 1'b0; go_stop = 1'b0;
    six = 2'b00; wv = 32'h0000_0000;
    b = sda_s;
    rx = (r.ph == PH_DATA) && r.rd_frame;
    if (s_axi_awvalid_i && r.awr) begin
      n.aw = 1'b1;
      n.wa = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && r.wrdy) begin
      n.w  = 1'b1;
      n.wd = s_axi_wdata_i;
      n.ws = s_axi_wstrb_i;
    end
    if (s_axi_bready_i && r.bv) n.bv = 1'b0;
    if (s_axi_rready_i && r.rv) n.rv = 1'b0;
    if (r.aw && r.w && !r.bv) begin
      wr_go = 1'b1;
      n.aw = 1'b0;
      n.w  = 1'b0;
      n.bv = 1'b1;
    end
    if (wr_go) begin
      case (wa_w)
        OFF_CTRL: begin
          if (r.wd[CR_SRST]) srst = 1'b1;
          else begin
            if (r.wd[CR_START]) n.start_pend = 1'b1;
            if (r.wd[CR_STOP]) n.stop_req = 1'b1;
            if (r.wd[CR_MON] && !r.wd[CR_MOFF]) begin
              n.en = 1'b1;
              n.flg[F_DONE] = 1'b1;
              n.flg[F_TXF] = 1'b1;
            end
            if (r.wd[CR_MOFF]) begin
              if (r.st == S_IDLE) n.en = 1'b0;
              else begin
                n.off_pend = 1'b1;
                if (r.rd_frame) n.stop_req = 1'b1;
              end
            end
          end
        end
        OFF_MODE: begin
          wv = mrg(mode_v, r.wd, r.ws);
          n.sz   = wv[MM_SZ_LO +: 2];
          n.mrd  = wv[MM_RD];
          n.slave_device_addr = wv[MM_DA_LO +: 7];
        end
        OFF_SUBA: begin
          wv = mrg({8'h00, r.suba}, r.wd, r.ws);
          n.suba = wv[23:0];
        end
        OFF_WAVE: begin
          wv = mrg(wave_v, r.wd, r.ws);
          n.cl = wv[WV_CL_LO +: 8];
          n.ch = wv[WV_CH_LO +: 8];
          n.ck = wv[WV_CK_LO +: 3];
        end
        OFF_IEN:  n.msk = r.msk | w2f(r.wd);
        OFF_IDIS: n.msk = r.msk & ~w2f(r.wd);
        OFF_TXH: begin
          n.thr = r.wd[7:0];
          n.thr_full = 1'b1;
          n.flg[F_TXF] = 1'b0;
          // write mode starts on data
          // data during the start, address or data bytes joins the running frame; during the stop it starts a new one
          if (!r.mrd && (r.st == S_IDLE || r.st == S_PLOW || r.st == S_PHIGH
              || r.st == S_PEND)) n.start_pend = 1'b1;
        end
        default: ;
      endcase
    end
    if (srst) begin
      n = '0;
      n.bv = 1'b1;
      // a read answer already offered must still complete
      n.rv = r.rv && !s_axi_rready_i;
      n.rd = r.rd;
    end
    if (s_axi_arvalid_i && r.arr) begin
      rd_go = 1'b1;
      rd_hit = 1'b1;
      n.rv = 1'b1;
      case (ra_w)
        OFF_MODE: n.rd = mode_v;
        OFF_SUBA: n.rd = {8'h00, r.suba};
        OFF_WAVE: n.rd = wave_v;
        OFF_STAT: begin
          n.rd = f2w(r.flg);
          n.flg[F_NAK] = 1'b0;
        end
        OFF_IMSK: n.rd = f2w(r.msk);
        OFF_RXH: begin
          n.rd = {24'h00_0000, r.rhr};
          n.flg[F_RXR] = 1'b0;
        end
        OFF_TXH: n.rd = {24'h00_0000, r.thr};
        default: begin
          n.rd = 32'h0000_0000;
          rd_hit = 1'b0;
        end
      endcase
    end
    if (!srst) begin
      if (r.st == S_IDLE) begin
        n.go = 1'b0;
        if (n.en && n.start_pend) begin
          n = mv(n, S_SRISE, 1'b0, 1'b0);
          n.start_pend = 1'b0;
          n.flg[F_DONE] = 1'b0;
          n.rd_frame = n.mrd;
          n.addr_rd  = n.mrd && (n.sz == 2'b00);
          n.sh = {n.slave_device_addr, n.mrd && (n.sz == 2'b00)};
          n.bitn = 4'h0;
          n.subn = n.sz;
          n.ph = PH_ADDR;
          n.last = 1'b0;
        end
      end else if (r.go) begin
        n.go = 1'b0;
        if (r.scl_oe) n.sda_oe = r.dbit;
      end else if (tdone) begin
        unique case (r.st)
          S_IDLE:  ;
          S_SRISE: n = mv(n, S_SFALL, 1'b0, 1'b1);
          S_SFALL: n = mv(n, S_BLOW, 1'b1, ~r.sh[7]);
          S_BLOW:  n = mv(n, S_BHIGH, 1'b0, r.sda_oe);
          S_PLOW:  n = mv(n, S_PHIGH, 1'b0, 1'b1);
          S_PHIGH: n = mv(n, S_PEND, 1'b0, 1'b0);
          S_RSLOW: n = mv(n, S_SRISE, 1'b0, 1'b0);
          S_PEND: begin
            n = mv(n, S_IDLE, 1'b0, 1'b0);
            n.flg[F_DONE] = 1'b1;
            n.stop_req = 1'b0;
            if (r.off_pend) begin
              n.en = 1'b0;
              n.off_pend = 1'b0;
            end
          end
          S_BHIGH: begin
            if (r.bitn != 4'h8) begin
              n.sh = {r.sh[6:0], b};
              n.bitn = r.bitn + 4'h1;
              if (r.bitn == 4'h7 && rx) begin
                n.rhr = {r.sh[6:0], b};
                n.flg[F_RXR] = 1'b1;
                n.last = n.stop_req;
              end
              n = mv(n, S_BLOW, 1'b1,
                     (r.bitn == 4'h7) ? (rx & ~n.last) : (~rx & ~r.sh[6]));
            end else begin
              n.bitn = 4'h0;
              if (rx) begin
                // start with stop means one byte
                if (r.last) go_stop = 1'b1;
                else n = mv(n, S_BLOW, 1'b1, 1'b0);
              end else if (b) begin
                n.flg = n.flg | 4'b1101;
                go_stop = 1'b1;
              end else begin
                unique case (r.ph)
                  PH_ADDR: begin
                    if (r.addr_rd) begin
                      n.ph = PH_DATA;
                      n = mv(n, S_BLOW, 1'b1, 1'b0);
                    end else if (r.subn != 2'b00) begin
                      n.ph = PH_SUB;
                      six = r.subn - 2'b01;
                      ld_sub = 1'b1;
                    end else ld_dat = 1'b1;
                  end
                  PH_SUB: begin
                    n.subn = r.subn - 2'b01;
                    if (n.subn != 2'b00) begin
                      six = n.subn - 2'b01;
                      ld_sub = 1'b1;
                    end else if (r.rd_frame) begin
                      n.addr_rd = 1'b1;
                      n.ph = PH_ADDR;
                      n.sh = {r.slave_device_addr, 1'b1};
                      n = mv(n, S_RSLOW, 1'b1, 1'b0);
                    end else ld_dat = 1'b1;
                  end
                  PH_DATA: ld_dat = 1'b1;
                endcase
              end
            end
          end
        endcase
      end
      if (ld_sub) begin
        n.sh = r.suba[{six, 3'b000} +: 8];
        ld_tx = 1'b1;
      end
      if (ld_dat) begin
        if (n.thr_full) begin
          n.sh = n.thr;
          n.thr_full = 1'b0;
          n.flg[F_TXF] = 1'b1;
          n.ph = PH_DATA;
          ld_tx = 1'b1;
        end else begin
          go_stop = 1'b1;
        end
      end
      if (ld_tx) n = mv(n, S_BLOW, 1'b1, ~n.sh[7]);
      if (go_stop) n = mv(n, S_PLOW, 1'b1, 1'b1);
    end
    n.awr  = !n.aw && !n.bv;
    n.wrdy = !n.w && !n.bv;
    n.arr  = !n.rv;
    n.irq  = |(n.flg & n.msk);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) r <= '0;
    else r <= n;
  end

  assign s_axi_awready_o       = r.awr;
  assign s_axi_wready_o        = r.wrdy;
  assign s_axi_bvalid_o        = r.bv;
  assign s_axi_bresp_o         = 2'b00;
  assign s_axi_arready_o       = r.arr;
  assign s_axi_rvalid_o        = r.rv;
  assign s_axi_rdata_o         = r.rd;
  assign s_axi_rresp_o         = 2'b00;
  assign serial_clock_pin_o    = 1'b0;
  assign serial_clock_pin_oe_o = r.scl_oe;
  assign serial_data_pin_o     = 1'b0;
  assign serial_data_pin_oe_o  = r.sda_oe;
  assign irq_o                 = r.irq;

  // ****************
  // checks
  // ****************
  logic [15:0] lvl_n;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) lvl_n <= 16'h0001;
    else if (n.scl_oe != r.scl_oe) lvl_n <= 16'h0001;
    else lvl_n <= lvl_n + 16'h0001;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ctl(int k);
    wr_go && wa_w == OFF_CTRL && r.wd[k] && !r.wd[CR_SRST];
  endsequence
  sequence s_ack_end;
    r.st == S_BHIGH && !r.go && tdone && r.bitn == 4'h8;
  endsequence

  AST_START_GO: assert property (s_ctl(CR_START) ##0 (r.en && r.st == S_IDLE && !r.wd[CR_MOFF])
    |=> r.st == S_SRISE) else $error("start did not launch");
  AST_THR_GO: assert property (wr_go && wa_w == OFF_TXH && !r.mrd && r.en && r.st == S_IDLE
    |=> r.st == S_SRISE && r.thr_full) else $error("data write did not launch");
  AST_RX_STOP: assert property (s_ack_end ##0 (rx && r.last) |=> r.st == S_PLOW ##1 r.sda_oe)
    else $error("read stop missing");
  AST_NAK_STOP: assert property (s_ack_end ##0 (!rx && b)
    |=> r.st == S_PLOW && r.flg[F_NAK] && r.flg[F_DONE] && r.flg[F_TXF])
    else $error("not_acked_flag handling wrong");
  AST_AUTO_STOP: assert property (s_ack_end ##0 (!rx && !b && r.ph == PH_DATA && !r.thr_full
    && !wr_go) |=> r.st == S_PLOW) else $error("write stop missing");
  AST_ENABLE: assert property (s_ctl(CR_MON) ##0 !r.wd[CR_MOFF]
    |=> r.en && r.flg[F_DONE] && r.flg[F_TXF]) else $error("enable failed");
  AST_SRST: assert property (wr_go && wa_w == OFF_CTRL && r.wd[CR_SRST]
    |=> r.st == S_IDLE && !r.en && r.msk == 4'h0 && r.cl == 8'h00) else $error("soft reset");
  AST_LOW_LEN: assert property ($fell(r.scl_oe) && $past(r.st) == S_BLOW
    |-> $past(lvl_n) == nlo) else $error("low phase length");
  AST_HIGH_LEN: assert property ($rose(r.scl_oe) && $past(r.st) == S_BHIGH
    |-> $past(lvl_n) == nhi) else $error("high phase length");
  AST_DONE: assert property (r.st == S_PEND && !r.go && tdone
    |=> r.st == S_IDLE && r.flg[F_DONE] && !r.scl_oe && !r.sda_oe) else $error("done flag");
  AST_RX_ACK: assert property (r.st == S_BLOW && r.bitn == 4'h8 && rx && !r.go
    |-> r.sda_oe == !r.last) else $error("master ack level");
  AST_IEN: assert property (wr_go && wa_w == OFF_IEN && r.wd[ST_NAK] |=> r.msk[F_NAK])
    else $error("mask not set");
  AST_IRQ: assert property (r.irq == (|(r.flg & r.msk))) else $error("irq mismatch");
  AST_UNMAP: assert property (rd_go && !rd_hit |=> r.rv && r.rd == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule

/* File: tb/twm_slave_model.sv */
// behavioural serial slave on the two shared lines
// assumes pulled-up lines resolved by the bench
`timescale 1ns/10ps
module twm_slave_model (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       nak_i,
  input  wire logic [7:0] rd_byte_i,
  output logic            sda_oe_o
);
  logic [7:0] sh;
  logic [7:0] log_q [$];
  logic       mack;
  logic       first;
  logic       rdp;
  int         cnt;
  initial begin
    sda_oe_o = 0;
    cnt = 0;
    rdp = 0;
    first = 0;
  end
  // start condition resets framing
  always @(negedge sda_i) if (scl_i) begin
    cnt = 0;
    first = 1;
    rdp = 0;
    mack = 0;
    sda_oe_o = 0;
  end
  always @(posedge scl_i) begin
    if (cnt < 8) sh = {sh[6:0], sda_i};
    else if (rdp) mack = sda_i;
    cnt++;
    if (cnt == 8) log_q.push_back(sh);
  end
  always @(negedge scl_i) begin
    if (cnt == 8) sda_oe_o = !rdp && !nak_i;
    else if (cnt == 9) begin
      cnt = 0;
      if (first) rdp = sh[0];
      else if (mack) rdp = 0;
      first = 0;
      sda_oe_o = rdp && !rd_byte_i[7];
    end else if (rdp && cnt > 0) sda_oe_o = !rd_byte_i[7-cnt];
  end
endmodule

/* File: tb/tb_two_wire_master_regs.sv */
// bench: bus tasks, random frames, slave model, verdict
// assumes the slave model is compiled first
`timescale 1ns/10ps
module tb_two_wire_master_regs;
  import twm_pkg::*;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, nak = 0, pv = 0;
  logic [7:0] awa = 0, ara = 0, rb = 0, dv;
  logic [31:0] wd = 0, rv, v, seed, nlo, nhi;
  wire awr, wrd, bv, arr, rvl, coe, doe, soe, irq;
  wire [31:0] rdat;
  wire [1:0] br, rr;
  wire cpo, dpo;
  wire scl = !coe;
  wire sda = !(doe | soe);
  int bad_count = 0, cmp_count = 0, run = 0, lo_len, hi_len;
  logic [7:0] offs [13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h24,
                           8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'hfc};
  always #12.5 clk = ~clk;
  twm_core uut (.sys_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rvl),
    .s_axi_rready_i(rry), .serial_clock_pin_o(cpo), .serial_clock_pin_oe_o(coe),
    .serial_data_pin_i(sda), .serial_data_pin_o(dpo), .serial_data_pin_oe_o(doe),
    .irq_o(irq));
  twm_slave_model slv (.scl_i(scl), .sda_i(sda), .nak_i(nak), .rd_byte_i(rb),
    .sda_oe_o(soe));
  // phase lengths, counted in clock cycles
  always @(posedge clk) begin
    if (coe !== pv) begin
      if (pv) lo_len = run;
      else hi_len = run;
      run = 1;
    end else run++;
    pv = coe;
  end
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (!bv);
    chk({30'h0, br}, 32'h0000_0000);
    bry <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ara <= a; arv <= 1; rry <= 1;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (!rvl);
    rv = rdat;
    chk({30'h0, rr}, 32'h0000_0000);
    rry <= 0;
  endtask
  task automatic poll(input int b);
    do rd(OFF_STAT); while (rv[b] !== 1'b1);
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    seed = 32'h18b5_45a3;
    repeat (2) @(posedge clk);
    rst <= 0;
    foreach (offs[i]) begin
      rd(offs[i]);
      chk(rv, 32'h0000_0000);
    end
    v = $random(seed);
    wr(OFF_MODE, v);
    rd(OFF_MODE);
    chk(rv, v & 32'h007f_1300);
    wr(OFF_SUBA, v);
    rd(OFF_SUBA);
    chk(rv, v & 32'h00ff_ffff);
    wr(OFF_CTRL, 32'h0000_0080);
    rd(OFF_MODE);
    chk(rv, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0004);
    rd(OFF_STAT);
    chk(rv, 32'h0000_0005);
    wr(OFF_IEN, 32'h0000_0107);
    wr(OFF_IDIS, 32'h0000_0004);
    rd(OFF_IMSK);
    chk(rv, 32'h0000_0103);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(OFF_IDIS, 32'h0000_0107);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      v = $random(seed);
      dv = $random(seed);
      nlo = ({30'h0, v[1:0]} << v[16]) + 3;
      nhi = ({30'h0, v[9:8]} << v[16]) + 3;
      wr(OFF_WAVE, {15'h0, v[16], 6'h0, v[9:8], 6'h0, v[1:0]});
      wr(OFF_MODE, {9'h0, dv[6:0], 6'h0, 2'b01, 8'h0});
      wr(OFF_SUBA, {24'h0, v[31:24]});
      slv.log_q.delete();
      wr(OFF_TXH, {24'h0, v[23:16]});
      rd(OFF_STAT);
      chk(rv & 32'h0000_0005, 32'h0000_0000);
      poll(ST_DONE);
      chk(rv, 32'h0000_0005);
      chk(slv.log_q.size(), 32'h0000_0003);
      chk(slv.log_q[0], {dv[6:0], 1'b0});
      chk(slv.log_q[1], v[31:24]);
      chk(slv.log_q[2], v[23:16]);
      chk(lo_len, nlo);
      chk(hi_len, nhi);
    end
    rb <= v[15:8];
    slv.log_q.delete();
    wr(OFF_MODE, {9'h0, dv[6:0], 3'h0, 1'b1, 12'h0});
    wr(OFF_CTRL, 32'h0000_0003);
    poll(ST_RXR);
    rd(OFF_RXH);
    chk(rv, {24'h0, v[15:8]});
    rd(OFF_STAT);
    chk(rv & 32'h0000_0002, 32'h0000_0000);
    poll(ST_DONE);
    chk(slv.log_q[0], {dv[6:0], 1'b1});
    chk({31'h0, slv.mack}, 32'h0000_0001);
    nak <= 1;
    wr(OFF_MODE, {9'h0, dv[6:0], 16'h0});
    wr(OFF_TXH, v);
    poll(ST_DONE);
    chk(rv, 32'h0000_0105);
    rd(OFF_STAT);
    chk(rv, 32'h0000_0005);
    nak <= 0;
    rb <= v[7:0];
    wr(OFF_MODE, {9'h0, dv[6:0], 3'h0, 1'b1, 12'h0});
    wr(OFF_CTRL, 32'h0000_0001);
    poll(ST_RXR);
    rd(OFF_RXH);
    chk(rv, {24'h0, v[7:0]});
    wr(OFF_CTRL, 32'h0000_0002);
    poll(ST_RXR);
    rd(OFF_RXH);
    chk(rv, {24'h0, v[7:0]});
    poll(ST_DONE);
    chk({31'h0, slv.mack}, 32'h0000_0001);
    chk({30'h0, cpo, dpo}, 32'h0000_0000);
    end_of_test;
  end
  initial begin
    #2_000_000;
    bad_count++;
    end_of_test;
  end
endmodule
